// *** logic/flash_section_guard.sv ***
// Flash section guard: lock checks, stall control and busy flag for self-programming.
`include "fsg_defs.svh"
// Operation
// - Store requests issued from the application region are ignored.
// - Stores issued from boot region may target any address unless locked.
// - Boot boundary comes from the fuse inputs, never from a register.
// - Programming an READ_WHILE_WRITE_REGION page leaves the CPU running, NO_READ_WHILE_WRITE_REGION readable.
// - Programming an NO_READ_WHILE_WRITE_REGION page halts the CPU; no flash is readable.
// - Boot region always lies inside the NO_READ_WHILE_WRITE_REGION region.
// - Busy flag reads one while the READ_WHILE_WRITE_REGION region is blocked.
// - Lock bits only clear to programmed; only chip erase or reset restores them.
// - General write lock does not affect store operations.
// - General read/write lock does not affect loads or stores.
// - Lock pair 11 places no restriction on its region.
// - Application pair 10 or 00 blocks stores into application region.
// - Application pair 00 or 01 blocks boot-run loads of application.
// - Application modes 3,4 with boot vectors mute interrupts in application.
// - Boot pair 10 or 00 blocks stores into boot region.
// - Boot pair 00 or 01 blocks application-run loads of boot.
// - Boot modes 3,4 with application vectors mute interrupts in boot.
// - Writing the re-enable bit after programming has ended clears busy and reopens READ_WHILE_WRITE_REGION reads.
module flash_section_guard
(
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic [31:0]         s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [31:0]         s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [1:0]          boot_size_fuses,
    input  wire logic                chip_erase,
    input  wire logic [`FSG_AW-1:0]  pc_addr,
    input  wire logic                spm_req,
    input  wire logic                spm_erase,
    input  wire logic [`FSG_AW-1:0]  spm_addr,
    input  wire logic                lpm_req,
    input  wire logic [`FSG_AW-1:0]  lpm_addr,
    output logic                     lpm_allow,
    output logic                     spm_accept,
    output logic                     spm_refuse,
    output logic                     flash_start,
    output logic                     flash_erase,
    output logic [`FSG_AW-1:0]       flash_addr,
    input  wire logic                flash_done,
    output logic                     cpu_halt,
    output logic                     rww_read_blocked,
    output logic                     irq_suppress
);
    fsg_region_if rg ();

    fsg_region_decode u_decode
    (
        .rg (rg)
    );

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] bsz_m_q;
    logic [1:0] bsz_s_q;
    logic       cer_m_q;
    logic       cer_s_q;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            bsz_m_q <= 2'h0;
            bsz_s_q <= 2'h0;
            cer_m_q <= 1'b0;
            cer_s_q <= 1'b0;
        end
        else
        begin
            bsz_m_q <= boot_size_fuses;
            bsz_s_q <= bsz_m_q;
            cer_m_q <= chip_erase;
            cer_s_q <= cer_m_q;
        end
    end

    assign rg.boot_size = bsz_s_q;
    assign rg.pc_addr   = pc_addr;
    assign rg.spm_addr  = spm_addr;
    assign rg.lpm_addr  = lpm_addr;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    fsg_pkg::fsg_state_t st_q, st_d;
    logic [3:0]          lock_q, lock_d;
    logic                vec_q, vec_d;
    logic                busy_q, busy_d;
    logic                refused_q, refused_d;
    logic                acc_q, acc_d, ref_q, ref_d, start_q, start_d, erase_q, erase_d;
    logic                irq_q, irq_d;
    logic [`FSG_AW-1:0]  faddr_q, faddr_d;
    logic                aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [31:0]         awa_q, awa_d, wd_q, wd_d, rd_q, rd_d, ara;
    logic [3:0]          ws_q, ws_d;
    logic [1:0]          br_q, br_d, rr_q, rr_d;
    logic                do_wr, wr_ctrl, wr_lock, reen_wr, spm_ok, app_blk, boot_blk;

    // a cleared low bit blocks stores, a set high bit leaves loads free
    assign app_blk  = rg.spm_in_boot ? 1'b0 : !lock_q[`FSG_LOCK_APP_LO];
    assign boot_blk = rg.spm_in_boot ? !lock_q[`FSG_LOCK_BOOT_LO] : 1'b0;

    // general lock bits play no part
    assign spm_ok = spm_req && (st_q == fsg_pkg::fsg_idle) && rg.pc_in_boot
                    && !app_blk && !boot_blk;

    assign do_wr   = aw_q && w_q && !bv_q;
    assign wr_ctrl = do_wr && (awa_q == `FSG_REG_CTRL) && ws_q[0];
    assign wr_lock = do_wr && (awa_q == `FSG_REG_LOCK) && ws_q[0];
    assign reen_wr = wr_ctrl && wd_q[`FSG_CTRL_REEN];
    assign ara     = s_axi_araddr;

    always_comb
    begin
        lpm_allow = lpm_req && (st_q != fsg_pkg::fsg_run_no_read_while_write_region);
        if (busy_q && rg.lpm_in_rww)
            lpm_allow = 1'b0;
        if (rg.pc_in_boot && !rg.lpm_in_boot && !lock_q[`FSG_LOCK_APP_HI])
            lpm_allow = 1'b0;
        if (!rg.pc_in_boot && rg.lpm_in_boot && !lock_q[`FSG_LOCK_BOOT_HI])
            lpm_allow = 1'b0;
    end

    always_comb
    begin
        st_d      = st_q;
        lock_d    = lock_q;
        vec_d     = vec_q;
        busy_d    = busy_q;
        refused_d = refused_q;
        acc_d     = 1'b0;
        ref_d     = 1'b0;
        start_d   = 1'b0;
        erase_d   = erase_q;
        faddr_d   = faddr_q;
        irq_d     = (!lock_q[`FSG_LOCK_APP_HI] && vec_q && !rg.pc_in_boot)
                    || (!lock_q[`FSG_LOCK_BOOT_HI] && !vec_q && rg.pc_in_boot);
        if (st_q != fsg_pkg::fsg_idle && flash_done)
            st_d = fsg_pkg::fsg_idle;
        // re-enable only takes effect once programming has ended
        if (reen_wr && st_q == fsg_pkg::fsg_idle)
            busy_d = 1'b0;
        // start; a new start wins over a same-cycle clear
        if (spm_ok)
        begin
            st_d      = rg.spm_in_rww ? fsg_pkg::fsg_run_rww : fsg_pkg::fsg_run_no_read_while_write_region;
            busy_d    = 1'b1;
            acc_d     = 1'b1;
            start_d   = 1'b1;
            erase_d   = spm_erase;
            faddr_d   = spm_addr;
            refused_d = 1'b0;
        end
        else if (spm_req)
        begin
            ref_d     = 1'b1;
            refused_d = 1'b1;
        end
        if (wr_ctrl)
            vec_d = wd_q[`FSG_CTRL_VEC];
        // writes can only program bits; chip erase restores them
        if (wr_lock)
            lock_d = lock_q & wd_q[3:0];
        if (cer_s_q)
            lock_d = `FSG_LOCK_RST;
    end

    // ---------------------------------------------------------------
    // AXI4-Lite slave
    // ---------------------------------------------------------------
    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready  = !w_q && !bv_q;
    assign s_axi_arready = !rv_q;

    always_comb
    begin
        aw_d  = aw_q;
        awa_d = awa_q;
        w_d   = w_q;
        wd_d  = wd_q;
        ws_d  = ws_q;
        bv_d  = bv_q;
        br_d  = br_q;
        rv_d  = rv_q;
        rd_d  = rd_q;
        rr_d  = rr_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_d  = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_d  = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb;
        end
        if (do_wr)
        begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            br_d = (awa_q == `FSG_REG_CTRL || awa_q == `FSG_REG_LOCK
                    || awa_q == `FSG_REG_STAT) ? `FSG_RESP_OKAY : `FSG_RESP_SLVERR;
        end
        if (bv_q && s_axi_bready)
            bv_d = 1'b0;
        if (rv_q && s_axi_rready)
            rv_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rv_d = 1'b1;
            rr_d = `FSG_RESP_OKAY;
            case (ara)
                `FSG_REG_CTRL: rd_d = {30'h0, vec_q, 1'b0};
                `FSG_REG_LOCK: rd_d = {28'h0, lock_q};
                `FSG_REG_STAT: rd_d = {26'h0, refused_q, bsz_s_q, st_q, busy_q};
                default:
                begin
                    rd_d = 32'h0;
                    rr_d = `FSG_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            st_q      <= fsg_pkg::fsg_idle;
            lock_q    <= `FSG_LOCK_RST;
            vec_q     <= 1'b0;
            busy_q    <= 1'b0;
            refused_q <= 1'b0;
            acc_q     <= 1'b0;
            ref_q     <= 1'b0;
            start_q   <= 1'b0;
            erase_q   <= 1'b0;
            irq_q     <= 1'b0;
            faddr_q   <= '0;
            aw_q      <= 1'b0;
            awa_q     <= 32'h0;
            w_q       <= 1'b0;
            wd_q      <= 32'h0;
            ws_q      <= 4'h0;
            bv_q      <= 1'b0;
            br_q      <= 2'h0;
            rv_q      <= 1'b0;
            rd_q      <= 32'h0;
            rr_q      <= 2'h0;
        end
        else
        begin
            st_q      <= st_d;
            lock_q    <= lock_d;
            vec_q     <= vec_d;
            busy_q    <= busy_d;
            refused_q <= refused_d;
            acc_q     <= acc_d;
            ref_q     <= ref_d;
            start_q   <= start_d;
            erase_q   <= erase_d;
            irq_q     <= irq_d;
            faddr_q   <= faddr_d;
            aw_q      <= aw_d;
            awa_q     <= awa_d;
            w_q       <= w_d;
            wd_q      <= wd_d;
            ws_q      <= ws_d;
            bv_q      <= bv_d;
            br_q      <= br_d;
            rv_q      <= rv_d;
            rd_q      <= rd_d;
            rr_q      <= rr_d;
        end
    end

    assign s_axi_bvalid     = bv_q;
    assign s_axi_bresp      = br_q;
    assign s_axi_rvalid     = rv_q;
    assign s_axi_rdata      = rd_q;
    assign s_axi_rresp      = rr_q;
    assign spm_accept       = acc_q;
    assign spm_refuse       = ref_q;
    assign flash_start      = start_q;
    assign flash_erase      = erase_q;
    assign flash_addr       = faddr_q;
    assign cpu_halt         = (st_q == fsg_pkg::fsg_run_no_read_while_write_region);
    assign rww_read_blocked = busy_q;
    assign irq_suppress     = irq_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_app_spm_ignored;
        @(posedge core_clk) disable iff (!reset_n)
        spm_req && !rg.pc_in_boot |=> spm_refuse && !flash_start;
    endproperty
    a_app_spm_ignored: assert property (p_app_spm_ignored) else $error("store from app ran");

    property p_boot_any_target;
        @(posedge core_clk) disable iff (!reset_n)
        spm_req && rg.pc_in_boot && st_q == fsg_pkg::fsg_idle && lock_q == 4'hF
        |=> flash_start && flash_addr == $past(spm_addr);
    endproperty
    a_boot_any_target: assert property (p_boot_any_target) else $error("free store refused");

    property p_fuse_boundary;
        @(posedge core_clk) disable iff (!reset_n)
        do_wr && $stable(bsz_s_q) |=> $stable(rg.boot_start);
    endproperty
    a_fuse_boundary: assert property (p_fuse_boundary) else $error("boundary moved by write");

    property p_rww_runs;
        @(posedge core_clk) disable iff (!reset_n)
        st_q == fsg_pkg::fsg_run_rww |-> !cpu_halt && busy_q;
    endproperty
    a_rww_runs: assert property (p_rww_runs) else $error("cpu halted on rww op");

    property p_no_read_while_write_region_halts;
        @(posedge core_clk) disable iff (!reset_n)
        cpu_halt |-> !lpm_allow && busy_q;
    endproperty
    a_no_read_while_write_region_halts: assert property (p_no_read_while_write_region_halts) else $error("read during no_read_while_write_region op");

    property p_boot_in_no_read_while_write_region;
        @(posedge core_clk) disable iff (!reset_n)
        rg.boot_start >= `FSG_NO_READ_WHILE_WRITE_REGION_START;
    endproperty
    a_boot_in_no_read_while_write_region: assert property (p_boot_in_no_read_while_write_region) else $error("boot region in rww");

    property p_busy_start;
        @(posedge core_clk) disable iff (!reset_n)
        spm_ok |=> busy_q [*2];
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy flag dropped");

    property p_lock_sticky;
        @(posedge core_clk) disable iff (!reset_n)
        !cer_s_q |=> (lock_q & ~$past(lock_q)) == 4'h0;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit unprogrammed");

    property p_store_lock;
        @(posedge core_clk) disable iff (!reset_n)
        spm_req && (app_blk || boot_blk) |=> !flash_start && spm_refuse;
    endproperty
    a_store_lock: assert property (p_store_lock) else $error("locked store started");

    property p_load_lock;
        @(posedge core_clk) disable iff (!reset_n)
        rg.pc_in_boot && !rg.lpm_in_boot && !lock_q[`FSG_LOCK_APP_HI] |-> !lpm_allow;
    endproperty
    a_load_lock: assert property (p_load_lock) else $error("locked load allowed");

    property p_reenable;
        @(posedge core_clk) disable iff (!reset_n)
        reen_wr && st_q == fsg_pkg::fsg_idle && !spm_ok |=> !busy_q && !rww_read_blocked;
    endproperty
    a_reenable: assert property (p_reenable) else $error("busy not cleared");

    c_rww_op:  cover property (@(posedge core_clk) st_q == fsg_pkg::fsg_run_rww ##1 flash_done);
    c_no_read_while_write_region_op: cover property (@(posedge core_clk) cpu_halt);
    c_refuse:  cover property (@(posedge core_clk) spm_refuse && rg.pc_in_boot);
endmodule

// *** logic/fsg_defs.svh ***
// Address map, register offsets, field positions and reset values of the flash section guard.
`ifndef FSG_DEFS_SVH
`define FSG_DEFS_SVH

// ---------------------------------------------------------------
// Flash geometry in words
// ---------------------------------------------------------------
`define FSG_AW            14
`define FSG_NO_READ_WHILE_WRITE_REGION_START    14'h3800
`define FSG_BOOT_START_00 14'h3800
`define FSG_BOOT_START_01 14'h3C00
`define FSG_BOOT_START_10 14'h3E00
`define FSG_BOOT_START_11 14'h3F00

// ---------------------------------------------------------------
// Register map on the AXI4-Lite slave
// ---------------------------------------------------------------
`define FSG_REG_CTRL      32'h0000_0000
`define FSG_REG_LOCK      32'h0000_0004
`define FSG_REG_STAT      32'h0000_0008
`define FSG_CTRL_REEN     0
`define FSG_CTRL_VEC      1
`define FSG_LOCK_APP_LO   0
`define FSG_LOCK_APP_HI   1
`define FSG_LOCK_BOOT_LO  2
`define FSG_LOCK_BOOT_HI  3
`define FSG_LOCK_RST      4'hF
`define FSG_RESP_OKAY     2'h0
`define FSG_RESP_SLVERR   2'h2

`endif

// *** logic/fsg_pkg.sv ***
// Types shared by the flash section guard modules.
package fsg_pkg;

    typedef enum logic [1:0]
    {
        fsg_idle     = 2'b00,
        fsg_run_rww  = 2'b01,
        fsg_run_no_read_while_write_region = 2'b10
    } fsg_state_t;

endpackage

// *** logic/fsg_region_if.sv ***
// Region decode signals between the guard and its address decoder.
`include "fsg_defs.svh"
interface fsg_region_if;
    logic [1:0]          boot_size;
    logic [`FSG_AW-1:0]  pc_addr;
    logic [`FSG_AW-1:0]  spm_addr;
    logic [`FSG_AW-1:0]  lpm_addr;
    logic [`FSG_AW-1:0]  boot_start;
    logic                pc_in_boot;
    logic                spm_in_boot;
    logic                spm_in_rww;
    logic                lpm_in_boot;
    logic                lpm_in_rww;

    modport decoder (input boot_size, pc_addr, spm_addr, lpm_addr,
                     output boot_start, pc_in_boot, spm_in_boot, spm_in_rww,
                     lpm_in_boot, lpm_in_rww);
    modport guard   (output boot_size, pc_addr, spm_addr, lpm_addr,
                     input boot_start, pc_in_boot, spm_in_boot, spm_in_rww,
                     lpm_in_boot, lpm_in_rww);
endinterface

// *** logic/fsg_region_decode.sv ***
// Decodes addresses into boot, application, READ_WHILE_WRITE_REGION and NO_READ_WHILE_WRITE_REGION regions.
`include "fsg_defs.svh"
module fsg_region_decode
(
    fsg_region_if.decoder rg
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic in_boot(input logic [`FSG_AW-1:0] a,
                                     input logic [`FSG_AW-1:0] start);
        in_boot = (a >= start);
    endfunction

    function automatic logic in_rww(input logic [`FSG_AW-1:0] a);
        in_rww = (a < `FSG_NO_READ_WHILE_WRITE_REGION_START);
    endfunction

    // ---------------------------------------------------------------
    // Boundary from fuses
    // ---------------------------------------------------------------
    // boot inside NO_READ_WHILE_WRITE_REGION
    // Every boot start lies at or above the NO_READ_WHILE_WRITE_REGION start, so the boot
    // region can never reach into the READ_WHILE_WRITE_REGION region.
    always_comb
    begin
        case (rg.boot_size)
            2'b00:   rg.boot_start = `FSG_BOOT_START_00;
            2'b01:   rg.boot_start = `FSG_BOOT_START_01;
            2'b10:   rg.boot_start = `FSG_BOOT_START_10;
            default: rg.boot_start = `FSG_BOOT_START_11;
        endcase
    end

    assign rg.pc_in_boot  = in_boot(rg.pc_addr, rg.boot_start);
    assign rg.spm_in_boot = in_boot(rg.spm_addr, rg.boot_start);
    assign rg.lpm_in_boot = in_boot(rg.lpm_addr, rg.boot_start);
    assign rg.spm_in_rww  = in_rww(rg.spm_addr);
    assign rg.lpm_in_rww  = in_rww(rg.lpm_addr);
endmodule

// *** testbench/fsg_flash_model.sv ***
// Behavioural flash array that ends each started operation after a set delay.
module fsg_flash_model
(
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       flash_start,
    input  wire logic [7:0] op_cycles,
    output logic            flash_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] count_q;
    // ----------------------------------------
    // Operation timer
    // ----------------------------------------
    // A zero delay would never finish, so the bench always sets at least one.
    always @(posedge core_clk)
    begin
        flash_done <= 1'b0;
        if (!reset_n)
            count_q <= 8'h00;
        else if (flash_start)
            count_q <= op_cycles;
        else if (count_q != 8'h00)
        begin
            count_q <= count_q - 8'h01;
            flash_done <= (count_q == 8'h01);
        end
    end
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the flash section guard.
`include "fsg_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
    logic        chip_erase, spm_req, spm_erase, lpm_req, awready, wready, bvalid;
    logic        arready, rvalid, lpm_allow, spm_accept, spm_refuse, flash_start;
    logic        flash_done, cpu_halt, busy, irq_sup;
    logic [31:0] awaddr, wdata, araddr, rdata, lf;
    logic [13:0] pc, spm_addr, lpm_addr;
    logic [13:0] bs [4];
    logic [1:0]  fuses, bresp, rresp;
    logic [1:0]  sp_q [$];
    logic [31:0] rd_q [$];
    logic [7:0]  dly;
    int          err_count, check_count, cyc;

    always #5 core_clk = ~core_clk;

    flash_section_guard dut_u
    (
        .core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .boot_size_fuses(fuses), .chip_erase(chip_erase),
        .pc_addr(pc), .spm_req(spm_req), .spm_erase(spm_erase), .spm_addr(spm_addr),
        .lpm_req(lpm_req), .lpm_addr(lpm_addr), .lpm_allow(lpm_allow),
        .spm_accept(spm_accept), .spm_refuse(spm_refuse), .flash_start(flash_start),
        .flash_erase(), .flash_addr(), .flash_done(flash_done),
        .cpu_halt(cpu_halt), .rww_read_blocked(busy), .irq_suppress(irq_sup)
    );

    fsg_flash_model flash_u
    (
        .core_clk(core_clk), .reset_n(reset_n), .flash_start(flash_start),
        .op_cycles(dly), .flash_done(flash_done)
    );

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Result monitor and hang guard
    // ----------------------------------------
    // Results are taken at the falling edge, where registered outputs have settled.
    always @(negedge core_clk)
    begin
        if (rvalid && rready)
            chk("rdata", rd_q.pop_front(), rdata);
        if (spm_accept || spm_refuse)
        begin
            chk("store", sp_q.pop_front(), {spm_accept, spm_refuse});
            chk("flash_start", spm_accept, flash_start);
        end
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end

    // Readies and valids are sampled mid-cycle; they hold until the next rising edge.
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ar_s, wr_s, bv_s;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge core_clk);
            ar_s = awready;
            wr_s = wready;
            bv_s = bvalid;
            @(posedge core_clk);
            if (ar_s) awvalid <= 1'b0;
            if (wr_s) wvalid <= 1'b0;
        end
        while (!bv_s);
        bready <= 1'b0;
        chk("bresp", r, bresp);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic ar_s, rv_s;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rd_q.push_back(e);
        do
        begin
            @(negedge core_clk);
            ar_s = arready;
            rv_s = rvalid;
            @(posedge core_clk);
            if (ar_s) arvalid <= 1'b0;
        end
        while (!rv_s);
        rready <= 1'b0;
        chk("rresp", `FSG_RESP_OKAY, rresp);
    endtask

    // Store request; the note is 10 for accept and 01 for refuse.
    task automatic sp(input logic [13:0] p, input logic [13:0] a, input logic [1:0] e);
        @(posedge core_clk);
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        pc <= p;
        spm_addr <= a;
        spm_erase <= lf[3];
        spm_req <= 1'b1;
        sp_q.push_back(e);
        @(posedge core_clk);
        spm_req <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic lp(input logic [13:0] p, input logic [13:0] a, input logic e);
        @(posedge core_clk);
        pc <= p;
        lpm_addr <= a;
        lpm_req <= 1'b1;
        @(negedge core_clk);
        chk("lpm_allow", e, lpm_allow);
    endtask

    // Software must clear busy before touching the READ_WHILE_WRITE_REGION region again.
    task automatic reopen;
        int n;
        n = 0;
        while (!flash_done && n < 300)
        begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        wr(`FSG_REG_CTRL, 32'h0000_0001, `FSG_RESP_OKAY);
        @(negedge core_clk);
        chk("busy", 1'b0, busy);
    endtask

    function automatic logic [13:0] app_addr(input logic [31:0] s);
        return {1'b0, s[12:0]};
    endfunction

    initial
    begin
        {core_clk, reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {chip_erase, spm_req, spm_erase, lpm_req, fuses} = '0;
        {awaddr, wdata, araddr, pc, spm_addr, lpm_addr} = '0;
        bs = '{`FSG_BOOT_START_00, `FSG_BOOT_START_01, `FSG_BOOT_START_10,
               `FSG_BOOT_START_11};
        lf = 32'h0001_78F1;
        dly = 8'h14;
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(`FSG_REG_LOCK, 32'h0000_000F);
        rd(`FSG_REG_CTRL, 32'h0000_0000);
        wr(32'h0000_0010, 32'h0000_0000, `FSG_RESP_SLVERR);
        sp(14'h0100, app_addr(lf), 2'b01);
        rd(`FSG_REG_STAT, 32'h0000_0020);
        $display("test registers and application store done");
        sp(14'h3900, app_addr(lf), 2'b10);
        chk("cpu_halt", 1'b0, cpu_halt);
        chk("busy", 1'b1, busy);
        lp(14'h3900, 14'h3A00, 1'b1);
        lp(14'h3900, 14'h0100, 1'b0);
        // software fetches only NO_READ_WHILE_WRITE_REGION code while the READ_WHILE_WRITE_REGION page is busy
        sp(14'h3900, app_addr(lf), 2'b01);
        repeat (30) @(posedge core_clk);
        lp(14'h3900, 14'h0100, 1'b0);
        reopen();
        lp(14'h3900, 14'h0100, 1'b1);
        $display("test rww programming done");
        dly = 8'h03;
        for (int f = 0; f < 4; f++)
        begin
            fuses <= f[1:0];
            repeat (4) @(posedge core_clk);
            sp(bs[f] - 14'h0001, bs[f], 2'b01);
            sp(bs[f], bs[f], 2'b10);
            chk("cpu_halt", 1'b1, cpu_halt);
            lp(bs[f], 14'h3800, 1'b0);
            reopen();
        end
        fuses <= 2'b00;
        repeat (4) @(posedge core_clk);
        $display("test boot size and no_read_while_write_region programming done");
        wr(`FSG_REG_LOCK, 32'hFFFF_FFFE, `FSG_RESP_OKAY);
        sp(14'h3900, app_addr(lf), 2'b01);
        lp(14'h3900, 14'h0200, 1'b1);
        wr(`FSG_REG_LOCK, 32'h0000_000C, `FSG_RESP_OKAY);
        lp(14'h3900, 14'h0200, 1'b0);
        wr(`FSG_REG_CTRL, 32'h0000_0002, `FSG_RESP_OKAY);
        lp(14'h0200, 14'h0300, 1'b1);
        @(negedge core_clk);
        chk("irq_suppress", 1'b1, irq_sup);
        wr(`FSG_REG_LOCK, 32'h0000_000F, `FSG_RESP_OKAY);
        rd(`FSG_REG_LOCK, 32'h0000_000C);
        wr(`FSG_REG_LOCK, 32'h0000_0003, `FSG_RESP_OKAY);
        sp(14'h3900, 14'h3A00, 2'b01);
        lp(14'h0200, 14'h3A00, 1'b0);
        wr(`FSG_REG_CTRL, 32'h0000_0000, `FSG_RESP_OKAY);
        lp(14'h3A00, 14'h3B00, 1'b1);
        @(negedge core_clk);
        chk("irq_suppress", 1'b1, irq_sup);
        $display("test lock modes done");
        chip_erase <= 1'b1;
        repeat (4) @(posedge core_clk);
        chip_erase <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(`FSG_REG_LOCK, 32'h0000_000F);
        lp(14'h0200, 14'h3A00, 1'b1);
        sp(14'h3900, app_addr(lf), 2'b10);
        reopen();
        $display("test chip erase done");
        chk("pending", 32'h0000_0000, rd_q.size() + sp_q.size());
        wrap_up();
    end
endmodule
